/* File: rtl/pdc_defs.vh */
// pdc_defs.vh: offsets, field positions, reset values and counts for the divider chain
// assumes a byte-wide register port and a 200 MHz core clock
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// register offsets (byte registers)
`define PDC_OFS_FB0      8'h00
`define PDC_OFS_FB1      8'h01
`define PDC_OFS_FB2      8'h02
`define PDC_OFS_FB3      8'h03
`define PDC_OFS_FB4      8'h04
`define PDC_OFS_FB5      8'h05
`define PDC_OFS_HS_LO    8'h06
`define PDC_OFS_HS_HI    8'h07
`define PDC_OFS_LS       8'h08
`define PDC_OFS_GAIN     8'h09
`define PDC_OFS_FSGAIN   8'h0a
`define PDC_OFS_STATUS   8'h0b

// field layout
`define PDC_FB_W         43
`define PDC_FB_INT_LSB   32
`define PDC_HS_W         11
`define PDC_LS_W         3
`define PDC_LS_SAT       3'h5

// reset values
`define PDC_FB_RST       43'h00480000000
`define PDC_HS_RST       11'h046
`define PDC_LS_RST       3'h0
`define PDC_GAIN_RST     8'h00
`define PDC_FSGAIN_RST   8'h80

// control voltage code at mid-supply
`define PDC_CV_MID       13'sh0800
// vco half-ticks between converter samples
`define PDC_SMP_TICKS    8'h10

`endif

/* File: rtl/pdc_divider_chain.v */
// pdc_divider_chain: feedback multiplier, control voltage pull, high and low speed dividers
// assumes synchronous register port and a sampled control voltage code from an outside converter
// Contract
// RULE1 - center frequency comes from host-written registers, not fixed settings
// RULE2 - feedback multiplier is 43-bit unsigned, 11 integer bits, 32 fraction bits
// RULE3 - host keeps feedback multiplier between 03C0000000 and 7FDFFFFFFF
// RULE4 - high speed divide ratio is an 11-bit unsigned binary ratio
// RULE5 - host keeps high speed ratio within 4 to 2046
// RULE6 - small and odd high speed ratios keep 50% output duty
// RULE7 - host uses even ratios 34 to 2046, odd only 5 to 33
// RULE8 - host prefers odd high speed ratios only with low speed divide by one
// RULE9 - low speed divider divides by two to the 3-bit exponent
// RULE10 - low speed exponents 5, 6, 7 all divide by 32
// RULE11 - all divider values are unsigned
// RULE12 - output equals vco divided by high speed times low speed ratio
// RULE13 - vco equals reference times effective feedback multiplier
// RULE14 - vco scaled by one plus control voltage offset times gain
// RULE15 - at mid-supply control voltage no frequency offset is applied
// RULE16 - host keeps vco within 10.8 GHz and 13.122222022 GHz
// RULE17 - host computes feedback values for a 152.6 MHz reference
// RULE18 - host rewrites converter full scale gain after changing vco
// RULE19 - converter sampling rate derives from the vco
// RULE20 - new feedback value applies only after all 43 bits are loaded
`timescale 1ns/1ps
`include "pdc_defs.vh"

module pdc_divider_chain (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_q,
  input  wire [11:0] control_voltage_pin,
  output reg         cv_sample_q,
  output reg         vco_half_q,
  output reg         hs_out_q,
  output reg         freq_out_q
);

  // staged and applied configuration
  reg  [`PDC_FB_W-1:0] fb_stage_q;
  reg  [`PDC_FB_W-1:0] feedback_multiplier_q;
  reg  [`PDC_HS_W-1:0] hs_stage_q;
  reg  [`PDC_HS_W-1:0] high_speed_divide_ratio_q;
  reg  [`PDC_LS_W-1:0] low_speed_divide_exponent_q;
  reg  [7:0]           ppm_per_volt_gain_q;
  reg  [7:0]           converter_full_scale_gain_q;
  reg                  fb_loaded_q;

  // frequency path
  reg  [31:0]          phase_q;
  reg  signed [12:0]   cv_off_q;
  reg  signed [31:0]   ppm_q;
  reg  signed [43:0]   fb_delta_q;
  reg  [7:0]           smp_cnt_q;
  reg  [`PDC_HS_W-1:0] hs_cnt_q;
  reg  [4:0]           ls_cnt_q;
  reg                  hs_prev_q;

  wire        wr_fb5 = reg_wr && (reg_addr == `PDC_OFS_FB5);
  wire        wr_hs  = reg_wr && (reg_addr == `PDC_OFS_HS_HI);
  wire        wr_fb0    = reg_wr && (reg_addr == `PDC_OFS_FB0);
  wire        wr_hs_lo  = reg_wr && (reg_addr == `PDC_OFS_HS_LO);
  wire        wr_ls     = reg_wr && (reg_addr == `PDC_OFS_LS);
  wire        wr_gain   = reg_wr && (reg_addr == `PDC_OFS_GAIN);
  wire        wr_fsgain = reg_wr && (reg_addr == `PDC_OFS_FSGAIN);

  // effective feedback multiplier, unsigned base plus signed pull
  wire signed [43:0] fb_signed = {1'b0, feedback_multiplier_q}; // RULE11
  wire signed [43:0] fb_eff_s  = fb_signed + fb_delta_q; // RULE14
  wire [42:0]        fb_eff    = fb_eff_s[43] ? 43'h0 : fb_eff_s[42:0];
  // scaled model: one core cycle stands for one reference period, vco = ref * fb / 2^11
  wire [31:0]        phase_d   = phase_q + fb_eff[42:11]; // RULE13
  wire               half_tick = phase_d[31] ^ phase_q[31];

  // pull term: (cv - mid) * gain * fsgain / 128, applied per 2^20 of multiplier
  wire signed [12:0] cv_s      = {1'b0, control_voltage_pin} - `PDC_CV_MID;
  wire signed [21:0] cv_gain   = cv_off_q * $signed({1'b0, ppm_per_volt_gain_q});
  wire signed [30:0] cv_full   = cv_gain * $signed({1'b0, converter_full_scale_gain_q});
  wire signed [23:0] fb_top    = {1'b0, feedback_multiplier_q[42:20]};
  wire signed [55:0] pull_prod = fb_top * ppm_q;

  // sign kept on purpose when the scaled terms widen into their registers
  wire signed [31:0] ppm_d     = {{8{cv_full[30]}}, cv_full[30:7]};
  wire signed [43:0] delta_d   = {{8{pull_prod[55]}}, pull_prod[55:20]};

  // low speed selection with saturation at divide by 32
  wire [2:0] ls_exp = (low_speed_divide_exponent_q > `PDC_LS_SAT) ?
                      `PDC_LS_SAT : low_speed_divide_exponent_q; // RULE10
  wire       hs_rise = hs_out_q & ~hs_prev_q;
  wire [4:0] ls_cnt_d = hs_rise ? ls_cnt_q + 5'h01 : ls_cnt_q;

  // register writes: low bytes of the multiplier are staged
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fb_stage_q <= `PDC_FB_RST;
    else if (reg_wr)
    begin
      case (reg_addr) // RULE1
        `PDC_OFS_FB0: fb_stage_q[7:0]   <= reg_wdata; // RULE2
        `PDC_OFS_FB1: fb_stage_q[15:8]  <= reg_wdata;
        `PDC_OFS_FB2: fb_stage_q[23:16] <= reg_wdata;
        `PDC_OFS_FB3: fb_stage_q[31:24] <= reg_wdata;
        `PDC_OFS_FB4: fb_stage_q[39:32] <= reg_wdata;
        `PDC_OFS_FB5: fb_stage_q[42:40] <= reg_wdata[2:0];
        default:      fb_stage_q        <= fb_stage_q;
      endcase
    end
  end

  // partial writes never reach the oscillator; top byte commits all 43 bits
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      feedback_multiplier_q <= `PDC_FB_RST;
    else if (wr_fb5)
      feedback_multiplier_q <= {reg_wdata[2:0], fb_stage_q[39:0]}; // RULE20
  end

  // status flag: low while a new multiplier is only half written
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fb_loaded_q <= 1'b1;
    else if (wr_fb0)
      fb_loaded_q <= 1'b0;
    else if (wr_fb5)
      fb_loaded_q <= 1'b1;
  end

  // high speed ratio: low byte staged so the divider never sees a mixed ratio
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hs_stage_q <= `PDC_HS_RST;
    else if (wr_hs_lo)
      hs_stage_q[7:0] <= reg_wdata;
    else if (wr_hs)
      hs_stage_q[10:8] <= reg_wdata[2:0];
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      high_speed_divide_ratio_q <= `PDC_HS_RST;
    else if (wr_hs)
      high_speed_divide_ratio_q <= {reg_wdata[2:0], hs_stage_q[7:0]}; // RULE4
  end

  // exponent kept as written; saturation happens where it is used
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      low_speed_divide_exponent_q <= `PDC_LS_RST;
    else if (wr_ls)
      low_speed_divide_exponent_q <= reg_wdata[2:0]; // RULE9
  end

  // pull gain, taken as an unsigned magnitude
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ppm_per_volt_gain_q <= `PDC_GAIN_RST;
    else if (wr_gain)
      ppm_per_volt_gain_q <= reg_wdata;
  end

  // full scale gain must be rewritten by the host whenever the vco moves
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      converter_full_scale_gain_q <= `PDC_FSGAIN_RST;
    else if (wr_fsgain)
      converter_full_scale_gain_q <= reg_wdata;
  end

  // register reads, registered one cycle after the strobe
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PDC_OFS_FB0:    reg_rdata_q <= feedback_multiplier_q[7:0];
        `PDC_OFS_FB1:    reg_rdata_q <= feedback_multiplier_q[15:8];
        `PDC_OFS_FB2:    reg_rdata_q <= feedback_multiplier_q[23:16];
        `PDC_OFS_FB3:    reg_rdata_q <= feedback_multiplier_q[31:24];
        `PDC_OFS_FB4:    reg_rdata_q <= feedback_multiplier_q[39:32];
        `PDC_OFS_FB5:    reg_rdata_q <= {5'h00, feedback_multiplier_q[42:40]};
        `PDC_OFS_HS_LO:  reg_rdata_q <= high_speed_divide_ratio_q[7:0];
        `PDC_OFS_HS_HI:  reg_rdata_q <= {5'h00, high_speed_divide_ratio_q[10:8]};
        `PDC_OFS_LS:     reg_rdata_q <= {5'h00, low_speed_divide_exponent_q};
        `PDC_OFS_GAIN:   reg_rdata_q <= ppm_per_volt_gain_q;
        `PDC_OFS_FSGAIN: reg_rdata_q <= converter_full_scale_gain_q;
        `PDC_OFS_STATUS: reg_rdata_q <= {4'h0, fb_loaded_q, freq_out_q, hs_out_q, vco_half_q};
        default:         reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // vco phase accumulator
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q    <= 32'h0;
      vco_half_q <= 1'b0;
    end
    else
    begin
      phase_q    <= phase_d;
      vco_half_q <= phase_d[31];
    end
  end

  // sample rate follows the vco, so it moves when the vco is retuned
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smp_cnt_q   <= 8'h00;
      cv_sample_q <= 1'b0;
      cv_off_q    <= 13'sh0;
    end
    else
    begin
      cv_sample_q <= 1'b0;
      if (half_tick)
      begin
        if (smp_cnt_q == `PDC_SMP_TICKS - 8'h01)
        begin
          smp_cnt_q   <= 8'h00;
          cv_sample_q <= 1'b1;
          cv_off_q    <= cv_s; // RULE19
        end
        else
          smp_cnt_q <= smp_cnt_q + 8'h01;
      end
    end
  end

  // pull pipeline, two stages so the wide products are not chained in one cycle
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ppm_q      <= 32'sh0;
      fb_delta_q <= 44'sh0;
    end
    else
    begin
      // mid-supply gives zero offset, so the multiplier is used unchanged
      ppm_q      <= ppm_d; // RULE15
      fb_delta_q <= delta_d; // RULE14
    end
  end

  // high speed divider counts vco half periods so odd ratios stay at 50% duty
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hs_cnt_q <= 11'h000;
      hs_out_q <= 1'b0;
    end
    else if (half_tick)
    begin
      // ratio n toggles every n half periods: period n, duty exactly half
      // a count left above a newly lowered ratio wraps at once, never runs away
      if (hs_cnt_q >= high_speed_divide_ratio_q - 11'h001)
      begin
        hs_cnt_q <= 11'h000;
        hs_out_q <= ~hs_out_q; // RULE6
      end
      else
        hs_cnt_q <= hs_cnt_q + 11'h001;
    end
  end

  // low speed divider counts rises of the high speed output
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hs_prev_q  <= 1'b0;
      ls_cnt_q   <= 5'h00;
      freq_out_q <= 1'b0;
    end
    else
    begin
      hs_prev_q <= hs_out_q;
      ls_cnt_q  <= ls_cnt_d;
      // divide by 2^e: bit e-1 of the rise counter, or the hs output itself
      // exponent 0 still passes one flop, so every setting has the same latency
      if (ls_exp == 3'h0)
        freq_out_q <= hs_out_q; // RULE12
      else
        freq_out_q <= ls_cnt_d[ls_exp - 3'h1]; // RULE9
    end
  end

endmodule // pdc_divider_chain

/* File: tb/pdc_chain_assertions.sv */
// pdc_chain_assertions: port checks for the divider chain
// assumes one clk domain, bound from the bench top
`timescale 1ns/1ps
module pdc_chain_assertions (
  input wire        clk,
  input wire        rst_b,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata_q,
  input wire [11:0] control_voltage_pin,
  input wire        cv_sample_q,
  input wire        vco_half_q,
  input wire        hs_out_q,
  input wire        freq_out_q
);
  // shadow of the exponent, the checker cannot see inside
  reg [2:0] ls_q;
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      ls_q <= 3'h0;
    else if (reg_wr && reg_addr == 8'h08)
      ls_q <= reg_wdata[2:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h0b |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  fb_top_a: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata_q[7:3] == 5'h0)
    else $error("multiplier top byte too wide");
  hs_top_a: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata_q[7:3] == 5'h0)
    else $error("ratio top byte too wide");
  ls_top_a: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata_q[7:3] == 5'h0)
    else $error("exponent too wide");
  ls_back_a: assert property (reg_wr && reg_addr == 8'h08 ##2 reg_rd && reg_addr == 8'h08
    |=> reg_rdata_q[2:0] == $past(reg_wdata[2:0], 3)) else $error("exponent not kept");
  cv_pulse_a: assert property (cv_sample_q |=> !cv_sample_q [*8])
    else $error("samples too close");
  ls_bypass_a: assert property (ls_q == 3'h0 && $past(ls_q) == 3'h0
    |-> freq_out_q == $past(hs_out_q)) else $error("divide by one not a delay");
endmodule // pdc_chain_assertions

/* File: tb/pdc_host_model.sv */
// pdc_host_model: host on the byte register port
// assumes read data lands on the taking edge and is read 1 ns after it
`timescale 1ns/1ps
module pdc_host_model (
  input  wire       clk,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata_q
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released lines show the inverse so stale values cannot pass
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input [7:0] a, output [7:0] d);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    {reg_addr, reg_rd} <= {~a, 1'b0};
    #1 d = reg_rdata_q;
  endtask
endmodule // pdc_host_model

/* File: tb/pdc_divider_chain_tb.sv */
// pdc_divider_chain_tb: self-checking bench for the divider chain
// assumes pdc_defs.vh on the include path
`timescale 1ns/1ps
`include "pdc_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module pdc_divider_chain_tb;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [11:0] cv = 12'h800;
  wire [7:0]  addr, wdata, rdata;
  wire        wr, rd, cvs, vh, hs, fo;
  wire [2:0]  obs = {cvs, fo, hs};
  int         errors = 0;
  int         cmp_count = 0;
  always #2.5 clk = ~clk;
  pdc_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata_q(rdata));
  pdc_divider_chain i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdata), .control_voltage_pin(cv),
    .cv_sample_q(cvs), .vco_half_q(vh), .hs_out_q(hs), .freq_out_q(fo));
  task automatic end_sim;
    $display("counts: %0d compared, %0d mismatched", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rchk(input [7:0] a, input [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    `CHK($sformatf("reg %0h", a), e, d)
  endtask
  // period and high time between the second and third rise
  task automatic pchk(input int s, input int ep, input int eh);
    int k, r, p, h;
    logic o;
    {r, p, h} = 0;
    o = obs[s];
    for (k = 0; k < 6000 && r < 3; k++)
    begin
      @(posedge clk);
      #1 r += obs[s] && !o;
      if (r == 2)
        {p, h} = {p + 1, h + obs[s]};
      o = obs[s];
    end
    if (r < 3)
    begin
      errors++;
      $display("mismatch rises %0d expected 3 seen %0d", s, r);
      end_sim();
    end
    `CHK($sformatf("period %0d", s), ep, p)
    `CHK($sformatf("high %0d", s), eh, h)
  endtask
  task automatic set_hs(input [10:0] n);
    i_host.wr(`PDC_OFS_HS_LO, n[7:0]);
    i_host.wr(`PDC_OFS_HS_HI, {5'h1f, n[10:8]});
  endtask
  task automatic t_reset;
    logic [63:0] v;
    int i;
    v = `PDC_FB_RST;
    for (i = 0; i < 6; i++)
      rchk(i, v[8*i +: 8]);
    v = `PDC_HS_RST;
    rchk(`PDC_OFS_HS_LO, v[7:0]);
    rchk(`PDC_OFS_HS_HI, v[15:8]);
    rchk(`PDC_OFS_LS, {5'h0, `PDC_LS_RST});
    rchk(`PDC_OFS_FSGAIN, `PDC_FSGAIN_RST);
    rchk(8'h0c, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_fb;
    logic [63:0] v;
    logic [7:0] d;
    int i;
    v = `PDC_FB_RST;
    for (i = 0; i < 5; i++)
      i_host.wr(i, 8'h00);
    rchk(`PDC_OFS_FB4, v[39:32]);
    i_host.rd(`PDC_OFS_STATUS, d);
    `CHK("loaded flag staged", 1'b0, d[3])
    i_host.wr(`PDC_OFS_FB5, 8'hfc);
    rchk(`PDC_OFS_FB5, 8'h04);
    rchk(`PDC_OFS_FB4, 8'h00);
    i_host.rd(`PDC_OFS_STATUS, d);
    `CHK("loaded flag applied", 1'b1, d[3])
    i_host.wr(`PDC_OFS_FSGAIN, 8'h40);
    rchk(`PDC_OFS_FSGAIN, 8'h40);
    $display("test feedback load done");
  endtask
  // multiplier 1024.0 makes one vco half tick per clock
  task automatic t_hs;
    int ns[4] = '{4, 5, 33, 34};
    int i;
    for (i = 0; i < 4; i++)
    begin
      set_hs(ns[i]);
      pchk(0, 2 * ns[i], ns[i]);
    end
    $display("test high speed done");
  endtask
  task automatic t_ls;
    int e, m;
    set_hs(6);
    for (e = 0; e < 8; e++)
    begin
      m = e > 5 ? 5 : e;
      i_host.wr(`PDC_OFS_LS, e);
      rchk(`PDC_OFS_LS, e);
      pchk(1, 12 << m, 6 << m);
    end
    $display("test low speed done");
  endtask
  task automatic t_cv;
    i_host.wr(`PDC_OFS_LS, 8'h00);
    i_host.wr(`PDC_OFS_GAIN, 8'hff);
    rchk(`PDC_OFS_GAIN, 8'hff);
    pchk(0, 12, 6);
    pchk(2, 16, 1);
    $display("test control voltage done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fb();
    t_hs();
    t_ls();
    t_cv();
    end_sim();
  end
endmodule // pdc_divider_chain_tb
bind pdc_divider_chain pdc_chain_assertions u_chk (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .control_voltage_pin(control_voltage_pin),
  .cv_sample_q(cv_sample_q), .vco_half_q(vco_half_q), .hs_out_q(hs_out_q),
  .freq_out_q(freq_out_q));
